// file: verilog/dts_device.sv
// Four-channel byte DMA transfer-mode sequencer, controller end
// Overview of operation
// [R1] Block mode runs until count end or stop
// [R2] Peripheral holds request only until acknowledge
// [R3] Block service end reloads when autoinit set
// [R4] Demand mode pauses on request drop, resumes
// [R5] Current address and count readable between bursts
// [R6] Demand pause never reloads; only count/stop
// [R7] After reload, fresh request edge needed
// [R8] Cascade: acknowledge only, no address/strobes
// [R9] Second-level hold wired to cascade channel
// [R10] Write type: I/O read with memory write
// [R11] Read type: memory read with I/O write
// [R12] Verify type: full sequencing, strobes idle
// [R13] Command bit pairs channels 0/1 memory-to-memory
// [R14] Ch0 source, ch1 destination, ch1 count
// [R15] Software request on ch0 starts move
// [R16] Software should use block mode for moves
// [R17] Fixed ch0 address fills block with byte
// [R18] Software masks 0/1, equal word counts
// [R19] No acknowledge during memory-to-memory moves
// [R20] External stop ends memory-to-memory move
// [R21] Each transfer steps count and address
// [R22] Move byte: four read, four write states
// [R23] External stop ends service after transfer
`timescale 1ns/1ns
`default_nettype none
module dts_device (
  input wire logic clk,
  input wire logic arst_n,
  dts_if.dev bus,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int NCH = dts_pkg::NCH;
  typedef enum {ST_IDLE, ST_HOLD, ST_XFER, ST_MRD, ST_MWR, ST_CASC} dts_state_t;

  function automatic logic [1:0] dts_first(input logic [NCH-1:0] v);
    dts_first = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        dts_first = i[1:0];
      end
    end
  endfunction

  dts_state_t st;
  logic [1:0] phase;
  logic [1:0] act;
  logic pair;
  logic eop_seen;
  logic [7:0] cmd;
  logic [3:0] mask;
  logic [3:0] swreq;
  logic [3:0] tc_stat;
  logic [3:0] armed;
  logic [5:0] mode [NCH];
  logic [15:0] base_addr [NCH];
  logic [15:0] base_cnt [NCH];
  logic [15:0] cur_addr [NCH];
  logic [15:0] cur_cnt [NCH];
  logic [7:0] temp;
  logic [3:0] hw_req;
  logic [3:0] elig;
  logic [1:0] win;
  logic ext_eop;
  logic last;
  logic finish_x;
  logic finish_m;
  logic done_cnt;
  logic ends;
  logic cont;
  logic [3:0] dec_cnt;
  logic [3:0] adv_addr;
  logic [3:0] reload;
  logic wr_ok;
  logic rd_take;
  logic [1:0] rch;
  logic [1:0] xtype;
  logic [1:0] smode;

  // ********************
  // Request qualification and end of service
  // ********************
  assign hw_req = bus.channel_request & ~mask & armed; // [R7]
  always_comb begin
    elig = hw_req | swreq;
    if (cmd[dts_pkg::CMD_M2M]) begin
      elig[1] = 1'b0; // [R13]
      elig[0] = swreq[0]; // [R15]
    end
  end
  assign win = dts_first(elig);
  // Our own drive of the line must not read back as an outside stop
  assign ext_eop = ~bus.end_of_process_line & bus.dev_eop_oe_n;
  assign xtype = mode[act][dts_pkg::MODE_TYPE_LSB +: 2];
  assign smode = mode[act][dts_pkg::MODE_SEL_LSB +: 2];
  assign last = (phase == dts_pkg::PHASE_LAST);
  assign finish_x = (st == ST_XFER) && last;
  assign finish_m = (st == ST_MWR) && last; // [R22]
  assign done_cnt = finish_m ? (cur_cnt[1] == dts_pkg::CNT_LAST) : (cur_cnt[act] == dts_pkg::CNT_LAST); // [R14]
  assign ends = (finish_x || finish_m) && (done_cnt || eop_seen || ext_eop); // [R23] [R20]
  always_comb begin
    case (smode)
      dts_pkg::SM_BLOCK: cont = 1'b1; // [R1]
      dts_pkg::SM_DEMAND: cont = bus.channel_request[act] | swreq[act]; // [R4]
      default: cont = 1'b0;
    endcase
  end
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      dec_cnt[c] = (finish_x && act == c[1:0]) || (finish_m && c < 2); // [R21]
      adv_addr[c] = dec_cnt[c] && !(finish_m && c == 0 && cmd[dts_pkg::CMD_HOLD0]); // [R17]
      reload[c] = dec_cnt[c] && ends && mode[c][dts_pkg::MODE_AUTO]; // [R3] [R6]
    end
  end

  // ********************
  // Sequencer
  // ********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_IDLE;
      phase <= 2'h0;
      act <= 2'h0;
      pair <= 1'b0;
      bus.bus_hold_request <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          // Wait for the previous grant to drop so a stale grant never starts service
          if (|elig && !bus.bus_hold_grant) begin
            st <= ST_HOLD;
            act <= win;
            pair <= cmd[dts_pkg::CMD_M2M] && win == 2'h0; // [R13]
            bus.bus_hold_request <= 1'b1;
          end
        end
        ST_HOLD: begin
          phase <= 2'h0;
          if (bus.bus_hold_grant) begin
            if (pair) begin
              st <= ST_MRD;
            end else if (smode == dts_pkg::SM_CASCADE) begin
              st <= ST_CASC; // [R8] [R9]
            end else begin
              st <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          phase <= phase + 2'h1;
          if (last && (ends || !cont)) begin
            st <= ST_IDLE; // [R4]
            bus.bus_hold_request <= 1'b0;
          end
        end
        ST_MRD: begin
          phase <= phase + 2'h1;
          if (last) begin
            st <= ST_MWR; // [R22]
          end
        end
        ST_MWR: begin
          phase <= phase + 2'h1;
          if (last && ends) begin
            st <= ST_IDLE;
            bus.bus_hold_request <= 1'b0;
          end else if (last) begin
            st <= ST_MRD;
          end
        end
        ST_CASC: begin
          if (!bus.channel_request[act]) begin
            st <= ST_IDLE; // [R8]
            bus.bus_hold_request <= 1'b0;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eop_seen <= 1'b0;
    end else if (st == ST_IDLE || st == ST_HOLD) begin
      eop_seen <= 1'b0;
    end else if (ext_eop) begin
      eop_seen <= 1'b1; // [R23]
    end
  end

  // ********************
  // Bus outputs
  // ********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.address <= 16'h0000;
      bus.bus_drive_n <= 1'b1;
      bus.memory_read_strobe <= 1'b1;
      bus.memory_write_strobe <= 1'b1;
      bus.io_read_strobe <= 1'b1;
      bus.io_write_strobe <= 1'b1;
      bus.data_oe_n <= 1'b1;
      bus.data_from_dev <= 8'h00;
      bus.channel_acknowledge <= 4'h0;
    end else begin
      bus.address <= (st == ST_MRD) ? cur_addr[0] : (st == ST_MWR) ? cur_addr[1] : cur_addr[act]; // [R14]
      bus.bus_drive_n <= !(st == ST_XFER || st == ST_MRD || st == ST_MWR); // [R8]
      bus.memory_read_strobe <= !((st == ST_XFER && !last && xtype == dts_pkg::XT_READ) || (st == ST_MRD && !last)); // [R11]
      bus.io_write_strobe <= !(st == ST_XFER && !last && xtype == dts_pkg::XT_READ); // [R11] [R12]
      bus.io_read_strobe <= !(st == ST_XFER && !last && xtype == dts_pkg::XT_WRITE); // [R10] [R12]
      bus.memory_write_strobe <= !((st == ST_XFER && !last && xtype == dts_pkg::XT_WRITE) || (st == ST_MWR && !last)); // [R10]
      bus.data_oe_n <= !(st == ST_MWR && !last);
      bus.data_from_dev <= temp;
      // Pair service keeps every acknowledge low
      bus.channel_acknowledge <= ((st == ST_XFER || st == ST_CASC) && !pair) ? (4'h1 << act) : 4'h0; // [R19] [R8]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp <= 8'h00;
    end else if (st == ST_MRD && last) begin
      temp <= bus.data_to_dev; // [R22]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.terminal_count <= 1'b0;
      bus.dev_eop_oe_n <= 1'b1;
    end else begin
      bus.terminal_count <= (finish_x || finish_m) && done_cnt;
      bus.dev_eop_oe_n <= !((finish_x || finish_m) && done_cnt);
    end
  end

  // ********************
  // Channel address and count
  // ********************
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && avs_waitrequest;
  assign rch = avs_address[3:2];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < NCH; c++) begin
        base_addr[c] <= 16'h0000;
        base_cnt[c] <= 16'h0000;
        cur_addr[c] <= 16'h0000;
        cur_cnt[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (reload[c]) begin
          cur_addr[c] <= base_addr[c]; // [R3] [R6]
          cur_cnt[c] <= base_cnt[c];
        end else if (dec_cnt[c]) begin
          cur_cnt[c] <= cur_cnt[c] - 16'h0001; // [R21]
          if (adv_addr[c] && mode[c][dts_pkg::MODE_DEC]) begin
            cur_addr[c] <= cur_addr[c] - 16'h0001;
          end else if (adv_addr[c]) begin
            cur_addr[c] <= cur_addr[c] + 16'h0001;
          end
        end else if (wr_ok && st == ST_IDLE && rch == c[1:0]) begin
          // Programming is taken only while idle so a burst never sees a torn value
          if ((avs_address & dts_pkg::GRP_MASK) == dts_pkg::GRP_ADDR) begin
            base_addr[c] <= avs_writedata[15:0];
            cur_addr[c] <= avs_writedata[15:0];
          end
          if ((avs_address & dts_pkg::GRP_MASK) == dts_pkg::GRP_CNT) begin
            base_cnt[c] <= avs_writedata[15:0];
            cur_cnt[c] <= avs_writedata[15:0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 4'hF;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!bus.channel_request[c]) begin
          armed[c] <= 1'b1; // [R7]
        end else if (reload[c]) begin
          armed[c] <= 1'b0; // [R7]
        end
      end
    end
  end

  // ********************
  // Control registers and Avalon-MM slave
  // ********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= dts_pkg::CMD_RST;
      mask <= dts_pkg::MASK_RST;
      for (int c = 0; c < NCH; c++) begin
        mode[c] <= dts_pkg::MODE_RST;
      end
    end else if (wr_ok) begin
      if (avs_address == dts_pkg::OFS_CMD) begin
        cmd <= avs_writedata[7:0];
      end
      if (avs_address == dts_pkg::OFS_MASK) begin
        mask <= avs_writedata[3:0];
      end
      if ((avs_address & dts_pkg::GRP_MASK) == dts_pkg::GRP_MODE) begin
        mode[rch] <= avs_writedata[5:0];
      end
    end
  end

  // Sets beat clears arriving in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swreq <= 4'h0;
      tc_stat <= 4'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_ok && avs_address == dts_pkg::OFS_SWREQ && avs_writedata[c]) begin
          swreq[c] <= 1'b1; // [R15]
        end else if (dec_cnt[c] && (ends || !cont)) begin
          swreq[c] <= 1'b0;
        end
        if (dec_cnt[c] && ends) begin
          tc_stat[c] <= 1'b1;
        end else if (rd_take && avs_address == dts_pkg::OFS_STAT) begin
          tc_stat[c] <= 1'b0;
        end
      end
    end
  end

  // One wait state per access; unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (rd_take) begin
        case (avs_address & dts_pkg::GRP_MASK)
          dts_pkg::GRP_MODE: avs_readdata <= {26'h0000000, mode[rch]};
          dts_pkg::GRP_ADDR: avs_readdata <= {16'h0000, cur_addr[rch]}; // [R5]
          dts_pkg::GRP_CNT: avs_readdata <= {16'h0000, cur_cnt[rch]}; // [R5]
          default: begin
            case (avs_address)
              dts_pkg::OFS_CMD: avs_readdata <= {24'h000000, cmd};
              dts_pkg::OFS_MASK: avs_readdata <= {28'h0000000, mask};
              dts_pkg::OFS_SWREQ: avs_readdata <= {28'h0000000, swreq};
              dts_pkg::OFS_STAT: avs_readdata <= {24'h000000, bus.channel_request, tc_stat};
              dts_pkg::OFS_TEMP: avs_readdata <= {24'h000000, temp};
              default: avs_readdata <= 32'h00000000;
            endcase
          end
        endcase
      end
    end
  end
endmodule // dts_device
`default_nettype wire

// file: verilog/dts_pkg.sv
// Shared constants and types of the transfer-mode sequencer
package dts_pkg;
  localparam int NCH = 4;
  localparam int AW = 16;
  localparam int DW = 8;
  // ********************
  // Register map (byte addresses)
  // ********************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_SWREQ = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_TEMP = 8'h10;
  localparam logic [7:0] GRP_MODE = 8'h20;
  localparam logic [7:0] GRP_ADDR = 8'h30;
  localparam logic [7:0] GRP_CNT = 8'h40;
  localparam logic [7:0] GRP_MASK = 8'hF0;
  // ********************
  // Field positions and reset values
  // ********************
  localparam int CMD_M2M = 0;
  localparam int CMD_HOLD0 = 1;
  localparam int MODE_TYPE_LSB = 0;
  localparam int MODE_AUTO = 2;
  localparam int MODE_DEC = 3;
  localparam int MODE_SEL_LSB = 4;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [15:0] CNT_LAST = 16'h0001;
  typedef enum logic [1:0] {XT_VERIFY, XT_WRITE, XT_READ, XT_RSVD} dts_xtype_t;
  typedef enum logic [1:0] {SM_DEMAND, SM_SINGLE, SM_BLOCK, SM_CASCADE} dts_smode_t;
endpackage

// file: verilog/dts_if.sv
// Link between the sequencer and the host/peripheral side
`timescale 1ns/1ns
`default_nettype none
interface dts_if;
  logic [dts_pkg::NCH-1:0] channel_request;
  logic [dts_pkg::NCH-1:0] channel_acknowledge;
  logic bus_hold_request;
  logic bus_hold_grant;
  logic dev_eop_oe_n;
  logic host_eop_oe_n;
  logic end_of_process_line;
  logic terminal_count;
  logic [dts_pkg::AW-1:0] address;
  logic bus_drive_n;
  logic memory_read_strobe;
  logic memory_write_strobe;
  logic io_read_strobe;
  logic io_write_strobe;
  logic [dts_pkg::DW-1:0] data_to_dev;
  logic [dts_pkg::DW-1:0] data_from_dev;
  logic data_oe_n;
  // Open-drain end of process, active low, low when either end drives
  assign end_of_process_line = dev_eop_oe_n & host_eop_oe_n;
  modport dev (
    input channel_request, bus_hold_grant, end_of_process_line, data_to_dev,
    output channel_acknowledge, bus_hold_request, dev_eop_oe_n, terminal_count, address, bus_drive_n,
    output memory_read_strobe, memory_write_strobe, io_read_strobe, io_write_strobe, data_from_dev, data_oe_n
  );
  modport host (
    output channel_request, bus_hold_grant, host_eop_oe_n, data_to_dev,
    input channel_acknowledge, bus_hold_request, end_of_process_line, terminal_count, address, bus_drive_n,
    input memory_read_strobe, memory_write_strobe, io_read_strobe, io_write_strobe, data_from_dev, data_oe_n
  );
endinterface
`default_nettype wire

// file: verilog/dts_host.sv
// Host and peripheral end: bus grant, request holding, stop line
`timescale 1ns/1ns
`default_nettype none
module dts_host (
  input wire logic clk,
  input wire logic arst_n,
  dts_if.host bus,
  input wire logic [3:0] periph_request,
  output logic [3:0] periph_acknowledge,
  input wire logic cpu_bus_free,
  output logic bus_granted,
  input wire logic stop_request,
  input wire logic [7:0] mem_read_data,
  output logic [15:0] dma_address,
  output logic [7:0] dma_write_data,
  output logic [3:0] dma_strobes,
  output logic tc_seen
);
  logic [3:0] held;

  // ********************
  // Request holding
  // ********************
  // A pulse is kept alive until its acknowledge, then let go
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held <= 4'h0;
      bus.channel_request <= 4'h0;
      periph_acknowledge <= 4'h0;
    end else begin
      held <= (held | periph_request) & ~bus.channel_acknowledge; // [R2]
      bus.channel_request <= periph_request | (held & ~bus.channel_acknowledge); // [R2]
      periph_acknowledge <= bus.channel_acknowledge;
    end
  end

  // ********************
  // Bus grant and stop line
  // ********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.bus_hold_grant <= 1'b0;
      bus_granted <= 1'b0;
      bus.host_eop_oe_n <= 1'b1;
      bus.data_to_dev <= 8'h00;
    end else begin
      bus.bus_hold_grant <= bus.bus_hold_request && (cpu_bus_free || bus.bus_hold_grant); // [R9]
      bus_granted <= bus.bus_hold_request && (cpu_bus_free || bus.bus_hold_grant);
      bus.host_eop_oe_n <= !stop_request; // [R20]
      bus.data_to_dev <= mem_read_data;
    end
  end

  // ********************
  // Observed transfer
  // ********************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_address <= 16'h0000;
      dma_write_data <= 8'h00;
      dma_strobes <= 4'h0;
      tc_seen <= 1'b0;
    end else begin
      dma_address <= bus.bus_drive_n ? 16'h0000 : bus.address;
      dma_write_data <= bus.data_oe_n ? 8'h00 : bus.data_from_dev;
      dma_strobes <= ~{bus.memory_read_strobe, bus.memory_write_strobe, bus.io_read_strobe, bus.io_write_strobe};
      tc_seen <= bus.terminal_count;
    end
  end
endmodule // dts_host
`default_nettype wire

// file: sim/dts_properties.sv
// Interface checker for the transfer-mode sequencer link
`timescale 1ns/1ns
`default_nettype none
module dts_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] channel_acknowledge,
  input wire logic bus_hold_request,
  input wire logic bus_hold_grant,
  input wire logic end_of_process_line,
  input wire logic terminal_count,
  input wire logic bus_drive_n,
  input wire logic memory_read_strobe,
  input wire logic memory_write_strobe,
  input wire logic io_read_strobe,
  input wire logic io_write_strobe,
  input wire logic data_oe_n
);
  // ********************
  // Strobe pairing and timing
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_write_pair: assert property ($fell(io_read_strobe) |->
    (!io_read_strobe && !memory_write_strobe)[*3] ##1 (io_read_strobe && memory_write_strobe))
    else $error("write transfer strobes out of step");
  a_read_pair: assert property ($fell(io_write_strobe) |->
    (!io_write_strobe && !memory_read_strobe)[*3] ##1 (io_write_strobe && memory_read_strobe))
    else $error("read transfer strobes out of step");
  a_io_exclusive: assert property (!(!io_read_strobe && !io_write_strobe))
    else $error("both io strobes active");
  a_strobe_drive: assert property ((!memory_read_strobe || !memory_write_strobe || !io_read_strobe
    || !io_write_strobe) |-> !bus_drive_n && bus_hold_grant)
    else $error("strobe active without owning the bus");
  // Only a move has memory read without io write, so this picks move cycles
  a_move_halves: assert property ($fell(memory_read_strobe) && io_write_strobe |->
    (!memory_read_strobe && memory_write_strobe)[*3] ##1 (memory_read_strobe && memory_write_strobe)
    ##1 !memory_write_strobe)
    else $error("move byte not four read then four write states");
  a_move_no_ack: assert property (!data_oe_n |->
    channel_acknowledge == 4'h0 && io_read_strobe && io_write_strobe)
    else $error("acknowledge or io strobe during move");
  a_tc_stop: assert property (terminal_count |-> !end_of_process_line ##1 !terminal_count)
    else $error("terminal count not a one cycle stop");
  a_ack_granted: assert property ($rose(|channel_acknowledge) |-> bus_hold_grant && bus_hold_request)
    else $error("acknowledge without granted hold");
  c_move: cover property (!data_oe_n);
  c_tc: cover property (terminal_count);
  c_cascade: cover property (|channel_acknowledge && bus_drive_n);
  c_pause: cover property ($fell(bus_hold_request) && !terminal_count);
endmodule // dts_properties
`default_nettype wire

// file: sim/dma_transfer_mode_sequencer_tb.sv
// Self-checking bench joining controller end and host end
`timescale 1ns/1ns
`default_nettype none
module dma_transfer_mode_sequencer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] periph_request = 4'h0;
  logic [3:0] periph_acknowledge;
  logic cpu_bus_free = 1'b1;
  logic bus_granted;
  logic stop_request = 1'b0;
  logic [7:0] mem_read_data = 8'h00;
  logic [15:0] dma_address;
  logic [7:0] dma_write_data;
  logic [3:0] dma_strobes;
  logic tc_seen;
  logic [3:0] ps = 4'h0;
  logic [15:0] a_last = 16'h0;
  logic [15:0] ra = 16'h0;
  logic [7:0] d_last = 8'h00;
  logic [31:0] r;
  int failures = 0;
  int checks_done = 0;
  int n_wr = 0, n_rd = 0, n_mr = 0, n_mw = 0, n_tc = 0;
  int s, k;
  always #10 clk = ~clk;
  dts_if bus_if ();
  dts_device u_dts_device (.clk(clk), .arst_n(arst_n), .bus(bus_if), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dts_host u_dts_host (.clk(clk), .arst_n(arst_n), .bus(bus_if), .periph_request(periph_request),
    .periph_acknowledge(periph_acknowledge), .cpu_bus_free(cpu_bus_free), .bus_granted(bus_granted),
    .stop_request(stop_request), .mem_read_data(mem_read_data), .dma_address(dma_address),
    .dma_write_data(dma_write_data), .dma_strobes(dma_strobes), .tc_seen(tc_seen));
  dts_properties u_dts_properties (.clk(clk), .arst_n(arst_n),
    .channel_acknowledge(bus_if.channel_acknowledge), .bus_hold_request(bus_if.bus_hold_request),
    .bus_hold_grant(bus_if.bus_hold_grant), .end_of_process_line(bus_if.end_of_process_line),
    .terminal_count(bus_if.terminal_count), .bus_drive_n(bus_if.bus_drive_n),
    .memory_read_strobe(bus_if.memory_read_strobe), .memory_write_strobe(bus_if.memory_write_strobe),
    .io_read_strobe(bus_if.io_read_strobe), .io_write_strobe(bus_if.io_write_strobe),
    .data_oe_n(bus_if.data_oe_n));
  // ********************
  // Transfer monitor on the host side, strobes as {mr,mw,ir,iw}
  // ********************
  always @(posedge clk) begin
    ps <= dma_strobes;
    if (dma_strobes != ps) begin
      case (dma_strobes)
        4'h6: begin n_wr++; a_last <= dma_address; end
        4'h9: begin n_rd++; a_last <= dma_address; end
        4'h8: begin n_mr++; ra <= dma_address; end
        4'h4: begin n_mw++; a_last <= dma_address; d_last <= dma_write_data; end
        default: ;
      endcase
    end
    if (tc_seen === 1'b1) n_tc++;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic lim(input logic hit);
    if (hit) begin
      failures++;
      $display("MISMATCH t=%0t wait limit reached", $time);
    end
  endtask
  // Request held until waitrequest is sampled low; no cycle count assumed
  task automatic av_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    lim(n >= 100);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic setup(input int c, input logic [5:0] m, input logic [15:0] a, input logic [15:0] n);
    av_acc(1'b1, dts_pkg::GRP_MODE + 8'(4 * c), {26'h0, m});
    av_acc(1'b1, dts_pkg::GRP_ADDR + 8'(4 * c), {16'h0, a});
    av_acc(1'b1, dts_pkg::GRP_CNT + 8'(4 * c), {16'h0, n});
  endtask
  task automatic wt_tc(input int t);
    for (int i = 0; i < 2000 && n_tc < t; i++) @(posedge clk);
    lim(n_tc < t);
  endtask
  task automatic wt_idle;
    for (int i = 0; i < 2000 && bus_if.bus_hold_request !== 1'b0; i++) @(posedge clk);
    lim(bus_if.bus_hold_request !== 1'b0);
  endtask
  task automatic wt_ack(input int c);
    for (int i = 0; i < 200 && periph_acknowledge[c] !== 1'b1; i++) @(posedge clk);
    lim(periph_acknowledge[c] !== 1'b1);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_regs;
    av_acc(1'b0, dts_pkg::OFS_MASK, 32'h0);
    chk(r, 32'h0000000F);
    av_acc(1'b0, 8'hE0, 32'h0);
    chk(r, 32'h0);
  endtask
  task automatic t_block;
    setup(1, 6'h25, 16'h0100, 16'h0003);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hD);
    periph_request <= 4'h2;
    wt_ack(1);
    periph_request <= 4'h0;
    wt_tc(1);
    chk(n_wr, 3);
    chk({16'h0, a_last}, 32'h0102);
    av_acc(1'b0, dts_pkg::GRP_ADDR + 8'h04, 32'h0);
    chk(r, 32'h0100);
    av_acc(1'b0, dts_pkg::GRP_CNT + 8'h04, 32'h0);
    chk(r, 32'h0003);
    periph_request <= 4'h2;
    wt_tc(2);
    repeat (40) @(posedge clk);
    chk(n_wr, 6);
    chk({31'h0, bus_if.bus_hold_request}, 32'h0);
    periph_request <= 4'h0;
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hF);
  endtask
  task automatic t_demand;
    setup(2, 6'h06, 16'h0200, 16'h0004);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hB);
    s = n_rd;
    periph_request <= 4'h4;
    for (int i = 0; i < 500 && n_rd < s + 2; i++) @(posedge clk);
    periph_request <= 4'h0;
    wt_idle();
    repeat (5) @(posedge clk);
    k = n_rd - s;
    chk({31'h0, k < 4}, 32'h1);
    av_acc(1'b0, dts_pkg::GRP_CNT + 8'h08, 32'h0);
    chk(r, 32'(4 - k));
    av_acc(1'b0, dts_pkg::GRP_ADDR + 8'h08, 32'h0);
    chk(r, 32'(16'h0200 + k));
    periph_request <= 4'h4;
    wt_tc(3);
    periph_request <= 4'h0;
    chk(n_rd - s, 4);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hF);
  endtask
  task automatic t_verify;
    setup(3, 6'h28, 16'h0040, 16'h0002);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'h7);
    s = n_wr + n_rd + n_mr + n_mw;
    periph_request <= 4'h8;
    wt_ack(3);
    periph_request <= 4'h0;
    wt_tc(4);
    chk(n_wr + n_rd + n_mr + n_mw, s);
    av_acc(1'b0, dts_pkg::GRP_ADDR + 8'h0C, 32'h0);
    chk(r, 32'h003E);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hF);
  endtask
  task automatic t_cascade;
    av_acc(1'b1, dts_pkg::GRP_MODE, 32'h30);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hE);
    k = 0;
    periph_request <= 4'h1;
    wt_ack(0);
    repeat (20) begin
      @(posedge clk);
      if (bus_if.bus_drive_n !== 1'b1 || periph_acknowledge[0] !== 1'b1 || bus_granted !== 1'b1) k++;
    end
    chk(k, 0);
    periph_request <= 4'h0;
    repeat (10) @(posedge clk);
    chk({28'h0, periph_acknowledge}, 32'h0);
    av_acc(1'b1, dts_pkg::OFS_MASK, 32'hF);
  endtask
  // Mask stays set: the move is started by software request only
  task automatic t_move;
    av_acc(1'b1, dts_pkg::OFS_CMD, 32'h3);
    setup(0, 6'h20, 16'h0500, 16'h0004);
    setup(1, 6'h20, 16'h0600, 16'h0004);
    mem_read_data <= 8'hA5;
    s = n_mw;
    av_acc(1'b1, dts_pkg::OFS_SWREQ, 32'h1);
    wt_tc(5);
    chk(n_mw - s, 4);
    chk({16'h0, a_last}, 32'h0603);
    chk({24'h0, d_last}, 32'hA5);
    chk({16'h0, ra}, 32'h0500);
    setup(1, 6'h20, 16'h0700, 16'h0004);
    av_acc(1'b1, dts_pkg::GRP_CNT, 32'h4);
    s = n_mw;
    av_acc(1'b1, dts_pkg::OFS_SWREQ, 32'h1);
    for (int i = 0; i < 500 && n_mw == s; i++) @(posedge clk);
    stop_request <= 1'b1;
    wt_idle();
    stop_request <= 1'b0;
    chk({31'h0, (n_mw - s) < 4}, 32'h1);
    av_acc(1'b0, dts_pkg::GRP_CNT + 8'h04, 32'h0);
    chk({31'h0, r != 32'h0}, 32'h1);
  endtask
  initial begin
    #1_000_000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_block();
    t_demand();
    t_verify();
    t_cascade();
    t_move();
    report_and_stop();
  end
endmodule // dma_transfer_mode_sequencer_tb
`default_nettype wire
